// ==== logic/alb_pkg.sv ====
// Constants, encodings and types shared by the datapath files.
package alb_pkg;
  // Widths
  localparam int DATA_W  = 8;
  localparam int FADDR_W = 7;
  localparam int INSTR_W = 14;
  localparam int PC_W    = 13;
  localparam int BADDR_W = 8;

  // Register byte offsets on the bus
  localparam logic [7:0] OFS_INSTR  = 8'h00;
  localparam logic [7:0] OFS_ACC    = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_CONFIG = 8'h0C;
  localparam logic [7:0] OFS_FADDR  = 8'h10;
  localparam logic [7:0] OFS_FDATA  = 8'h14;
  localparam logic [7:0] OFS_PC     = 8'h18;

  // Status register bit positions
  localparam int ST_C       = 0;
  localparam int ST_DC      = 1;
  localparam int ST_Z       = 2;
  localparam int ST_BUSY    = 3;
  localparam int ST_DISCARD = 4;

  // Config register bit: prescaler belongs to timer zero
  localparam int CFG_PSA_T0 = 0;

  // File addresses with side effects
  localparam logic [6:0] FA_TIMER_ZERO = 7'h01;
  localparam logic [6:0] FA_PORT       = 7'h05;

  // Instruction field positions
  localparam int F_DEST   = 7;
  localparam int F_BIT_LO = 7;
  localparam int F_BIT_HI = 9;

  // Opcode patterns
  localparam logic [5:0] OPC_ADD_FILE = 6'h07;
  localparam logic [5:0] OPC_AND_FILE = 6'h05;
  localparam logic [5:0] OPC_AND_LIT  = 6'h39;
  localparam logic [4:0] OPC_ADD_LIT  = 5'h1F;
  localparam logic [3:0] OPC_POS_CLR  = 4'h4;
  localparam logic [3:0] OPC_POS_SET  = 4'h5;
  localparam logic [3:0] OPC_POS_TSTZ = 4'h6;

  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // Decoded operations
  typedef enum logic [2:0] {
    OP_NOP,
    OP_ADD_LIT,
    OP_ADD_FILE,
    OP_AND_LIT,
    OP_AND_FILE,
    OP_POS_CLR,
    OP_POS_SET,
    OP_POS_TSTZ
  } alb_op_t;

  // Executor states, one-hot
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_EXEC = 3'b010,
    S_NOP  = 3'b100
  } alb_state_t;
endpackage

// ==== logic/alb_mem_if.sv ====
// Connection between the executor and its file-register memory.
`timescale 1ns/1ps
`default_nettype none
interface alb_mem_if #(
  parameter int AW = 7,
  parameter int DW = 8
);
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;

  modport core (output raddr, output we, output waddr, output wdata,
                input rdata);
  modport mem  (input raddr, input we, input waddr, input wdata,
                output rdata);
endinterface
`default_nettype wire

// ==== logic/alb_filemem.sv ====
// File-register memory with a registered read port.
`timescale 1ns/1ps
`default_nettype none
module alb_filemem #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  // Clock
  input wire logic MCLK,
  // Memory port
  alb_mem_if.mem   port
);
  logic [DW-1:0] mem_arr [0:(1<<AW)-1];
  logic [DW-1:0] rdata_reg;

  // Write port; no reset so it maps onto plain RAM
  always_ff @(posedge MCLK)
  begin
    if (port.we)
    begin
      mem_arr[port.waddr] <= port.wdata;
    end
  end

  // Read data come out of a register, one cycle after the address
  always_ff @(posedge MCLK)
  begin
    rdata_reg <= mem_arr[port.raddr];
  end

  assign port.rdata = rdata_reg;
endmodule
`default_nettype wire

// ==== logic/alb_core.sv ====
// Arithmetic, logic and bit-operation datapath with an AHB-Lite slave.
//
// Design decisions made here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [RULE1] Read-modify-write of the port register uses the pin levels.
// [RULE2] File write to timer zero count clears prescaler when assigned; here only executed writes do, bus FDATA writes do not.
// [RULE3] Program counter change or true test costs two cycles, second NOP.
// [RULE4] Add literal: accumulator plus literal to accumulator, C DC Z.
// [RULE5] Add file: accumulator plus file, dest bit picks target, C DC Z.
// [RULE6] AND file: accumulator AND file to chosen target, Z only.
// [RULE7] AND literal: accumulator AND literal to accumulator, Z only.
// [RULE8] Position clear zeroes one file bit, flags untouched.
// [RULE9] Position set forces one file bit high, flags untouched.
// [RULE10] Test position: zero bit discards next instruction, two cycles.
// [RULE11] Z on zero result, C from bit 7, half-carry from bit 3.
module alb_core #(
  parameter int DATA_W  = alb_pkg::DATA_W,
  parameter int FADDR_W = alb_pkg::FADDR_W,
  parameter int PC_W    = alb_pkg::PC_W
) (
  // Clock and reset
  input  wire logic              MCLK,
  input  wire logic              RSTN,
  // AHB-Lite slave
  input  wire logic              HSEL,
  input  wire logic [31:0]       HADDR,
  input  wire logic [1:0]        HTRANS,
  input  wire logic              HWRITE,
  input  wire logic [2:0]        HSIZE,
  input  wire logic [31:0]       HWDATA,
  input  wire logic              HREADY,
  output logic      [31:0]       HRDATA,
  output logic                   HREADYOUT,
  output logic                   HRESP,
  // I/O port pins
  input  wire logic [DATA_W-1:0] PORT_PIN_IN,
  output logic      [DATA_W-1:0] PORT_LATCH_OUT,
  // Timer zero and core state
  output logic                   TIMER_ZERO_PRESCALER_CLR,
  output logic      [PC_W-1:0]   PROGRAM_COUNTER
);
  // Operation decode from an instruction word
  function automatic alb_pkg::alb_op_t decode_op(
    input logic [alb_pkg::INSTR_W-1:0] iw
  );
    alb_pkg::alb_op_t op;
    op = alb_pkg::OP_NOP;
    if (iw[13:8] == alb_pkg::OPC_ADD_FILE)
      op = alb_pkg::OP_ADD_FILE;
    else if (iw[13:8] == alb_pkg::OPC_AND_FILE)
      op = alb_pkg::OP_AND_FILE;
    else if (iw[13:8] == alb_pkg::OPC_AND_LIT)
      op = alb_pkg::OP_AND_LIT;
    else if (iw[13:9] == alb_pkg::OPC_ADD_LIT)
      op = alb_pkg::OP_ADD_LIT;
    else if (iw[13:10] == alb_pkg::OPC_POS_CLR)
      op = alb_pkg::OP_POS_CLR;
    else if (iw[13:10] == alb_pkg::OPC_POS_SET)
      op = alb_pkg::OP_POS_SET;
    else if (iw[13:10] == alb_pkg::OPC_POS_TSTZ)
      op = alb_pkg::OP_POS_TSTZ;
    return op;
  endfunction

  alb_mem_if #(.AW(FADDR_W), .DW(DATA_W)) mem_bus ();

  // Bus data-phase state
  logic                   dp_active_reg;
  logic                   dp_write_reg;
  logic [7:0]             dp_addr_reg;
  logic                   mem_wait_reg;
  logic                   hready_reg;
  logic                   hresp_reg;
  logic [31:0]            hrdata_reg;
  logic [31:0]            hrdata_next;
  logic                   addr_take;
  logic                   fdata_rd;
  logic                   bus_done;
  logic                   bus_wr;
  logic                   issue;

  // Programmer-visible state
  alb_pkg::alb_state_t    state_reg;
  logic [13:0]            instr_reg;
  logic [DATA_W-1:0]      acc_reg;
  logic                   c_reg;
  logic                   dc_reg;
  logic                   z_reg;
  logic                   discard_reg;
  logic                   psa_t0_reg;
  logic [FADDR_W-1:0]     faddr_reg;
  logic [DATA_W-1:0]      port_latch_reg;
  logic                   psc_clr_reg;
  logic [PC_W-1:0]        pc_reg;

  // Execute-stage values
  alb_pkg::alb_op_t       op;
  logic [FADDR_W-1:0]     ex_f;
  logic [2:0]             ex_bit;
  logic [DATA_W-1:0]      ex_lit;
  logic [DATA_W-1:0]      operand;
  logic [DATA_W-1:0]      addend;
  logic [DATA_W:0]        sum;
  logic [4:0]             half_sum;
  logic [DATA_W-1:0]      result;
  logic                   to_file;
  logic                   to_acc;
  logic                   is_add;
  logic                   is_logic;
  logic                   skip_taken;
  logic                   ex_active;

  // Address phase is taken only with HREADY high
  assign addr_take = HSEL && HTRANS[1] && HREADY;
  assign fdata_rd  = !dp_write_reg && (dp_addr_reg == alb_pkg::OFS_FDATA);
  // The bus only acts while the executor is idle, so the two never race
  assign bus_done  = dp_active_reg && (state_reg == alb_pkg::S_IDLE)
                     && !(fdata_rd && !mem_wait_reg);
  assign bus_wr    = bus_done && dp_write_reg;
  assign issue     = bus_wr && (dp_addr_reg == alb_pkg::OFS_INSTR);

  // Data-phase tracking; every transfer gets at least one wait state
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      dp_active_reg <= 1'b0;
      dp_write_reg  <= 1'b0;
      dp_addr_reg   <= 8'h00;
      hready_reg    <= 1'b1;
      mem_wait_reg  <= 1'b0;
    end
    else if (addr_take && !dp_active_reg)
    begin
      dp_active_reg <= 1'b1;
      dp_write_reg  <= HWRITE;
      dp_addr_reg   <= HADDR[alb_pkg::BADDR_W-1:0];
      hready_reg    <= 1'b0;
    end
    else if (bus_done)
    begin
      dp_active_reg <= 1'b0;
      hready_reg    <= 1'b1;
      mem_wait_reg  <= 1'b0;
    end
    else if (dp_active_reg && fdata_rd
             && state_reg == alb_pkg::S_IDLE)
    begin
      mem_wait_reg  <= 1'b1; // Memory read address issued this cycle
    end
  end

  // Response is always OKAY
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      hresp_reg <= 1'b0;
    else
      hresp_reg <= 1'b0;
  end

  // Read multiplexer; unmapped offsets read zero
  always_comb
  begin
    hrdata_next = alb_pkg::RST_WORD;
    unique case (dp_addr_reg)
      alb_pkg::OFS_INSTR:  hrdata_next[13:0] = instr_reg;
      alb_pkg::OFS_ACC:    hrdata_next[DATA_W-1:0] = acc_reg;
      alb_pkg::OFS_STATUS:
      begin
        hrdata_next[alb_pkg::ST_C]       = c_reg;
        hrdata_next[alb_pkg::ST_DC]      = dc_reg;
        hrdata_next[alb_pkg::ST_Z]       = z_reg;
        hrdata_next[alb_pkg::ST_BUSY]    = state_reg != alb_pkg::S_IDLE;
        hrdata_next[alb_pkg::ST_DISCARD] = discard_reg;
      end
      alb_pkg::OFS_CONFIG: hrdata_next[alb_pkg::CFG_PSA_T0] = psa_t0_reg;
      alb_pkg::OFS_FADDR:  hrdata_next[FADDR_W-1:0] = faddr_reg;
      alb_pkg::OFS_FDATA:  hrdata_next[DATA_W-1:0] = mem_bus.rdata;
      alb_pkg::OFS_PC:     hrdata_next[PC_W-1:0] = pc_reg;
      default:             hrdata_next = alb_pkg::RST_WORD;
    endcase
  end

  // Read data register, loaded as the transfer completes
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      hrdata_reg <= alb_pkg::RST_WORD;
    else if (bus_done && !dp_write_reg)
      hrdata_reg <= hrdata_next;
  end

  // Execute-stage field extraction
  assign op        = decode_op(instr_reg);
  assign ex_f      = instr_reg[FADDR_W-1:0];
  assign ex_bit    = instr_reg[alb_pkg::F_BIT_HI:alb_pkg::F_BIT_LO];
  assign ex_lit    = instr_reg[DATA_W-1:0];
  assign ex_active = state_reg == alb_pkg::S_EXEC;

  // Port reads see the pins, not the latch
  assign operand = (ex_f == alb_pkg::FA_PORT) ? PORT_PIN_IN
                   : mem_bus.rdata; // [RULE1]

  // Adder shared by both add forms
  assign addend   = (op == alb_pkg::OP_ADD_LIT) ? ex_lit : operand;
  assign sum      = {1'b0, acc_reg} + {1'b0, addend}; // [RULE4] [RULE5]
  assign half_sum = {1'b0, acc_reg[3:0]} + {1'b0, addend[3:0]}; // [RULE11]

  // Result and destination selection
  always_comb
  begin
    result     = acc_reg;
    to_file    = 1'b0;
    to_acc     = 1'b0;
    is_add     = 1'b0;
    is_logic   = 1'b0;
    skip_taken = 1'b0;
    unique case (op)
      alb_pkg::OP_ADD_LIT:
      begin
        result = sum[DATA_W-1:0]; // [RULE4]
        to_acc = 1'b1;
        is_add = 1'b1;
      end
      alb_pkg::OP_ADD_FILE:
      begin
        result  = sum[DATA_W-1:0]; // [RULE5]
        to_file = instr_reg[alb_pkg::F_DEST];
        to_acc  = !instr_reg[alb_pkg::F_DEST];
        is_add  = 1'b1;
      end
      alb_pkg::OP_AND_LIT:
      begin
        result   = acc_reg & ex_lit; // [RULE7]
        to_acc   = 1'b1;
        is_logic = 1'b1;
      end
      alb_pkg::OP_AND_FILE:
      begin
        result   = acc_reg & operand; // [RULE6]
        to_file  = instr_reg[alb_pkg::F_DEST];
        to_acc   = !instr_reg[alb_pkg::F_DEST];
        is_logic = 1'b1;
      end
      alb_pkg::OP_POS_CLR:
      begin
        result          = operand; // [RULE8]
        result[ex_bit]  = 1'b0;
        to_file         = 1'b1;
      end
      alb_pkg::OP_POS_SET:
      begin
        result          = operand; // [RULE9]
        result[ex_bit]  = 1'b1;
        to_file         = 1'b1;
      end
      alb_pkg::OP_POS_TSTZ:
        skip_taken = !operand[ex_bit]; // [RULE10]
      alb_pkg::OP_NOP:
        result = acc_reg;
    endcase
  end

  // Memory port: issue reads f at once, bus reads the pointer
  assign mem_bus.raddr = issue ? HWDATA[FADDR_W-1:0] : faddr_reg;
  assign mem_bus.we    = (ex_active && to_file)
                         || (bus_wr && dp_addr_reg == alb_pkg::OFS_FDATA);
  assign mem_bus.waddr = ex_active ? ex_f : faddr_reg;
  assign mem_bus.wdata = ex_active ? result : HWDATA[DATA_W-1:0];

  alb_filemem #(.AW(FADDR_W), .DW(DATA_W)) u_filemem (
    .MCLK (MCLK),
    .port (mem_bus)
  );

  // Executor sequencing; a discarded word never reaches execute
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      state_reg <= alb_pkg::S_IDLE;
    else
    begin
      unique case (state_reg)
        alb_pkg::S_IDLE:
          if (issue && !discard_reg)
            state_reg <= alb_pkg::S_EXEC;
        alb_pkg::S_EXEC:
          if (skip_taken)
            state_reg <= alb_pkg::S_NOP; // [RULE3] [RULE10]
          else
            state_reg <= alb_pkg::S_IDLE;
        alb_pkg::S_NOP:
          state_reg <= alb_pkg::S_IDLE; // [RULE3]
        default:
          state_reg <= alb_pkg::S_IDLE;
      endcase
    end
  end

  // Instruction register
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      instr_reg <= 14'h0000;
    else if (issue && !discard_reg)
      instr_reg <= HWDATA[alb_pkg::INSTR_W-1:0];
  end

  // Skip bookkeeping: the next issued word is thrown away
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      discard_reg <= 1'b0;
    else if (ex_active && skip_taken)
      discard_reg <= 1'b1; // [RULE10]
    else if (issue)
      discard_reg <= 1'b0;
  end

  // Program counter advances once per instruction cycle, NOP included
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      pc_reg <= '0;
    else if (ex_active || state_reg == alb_pkg::S_NOP)
      pc_reg <= pc_reg + 1'b1; // [RULE3]
  end

  // Accumulator; software may preload it while idle
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      acc_reg <= '0;
    else if (ex_active && to_acc)
      acc_reg <= result; // [RULE5] [RULE6]
    else if (bus_wr && dp_addr_reg == alb_pkg::OFS_ACC)
      acc_reg <= HWDATA[DATA_W-1:0];
  end

  // Status flags; bit operations leave them alone
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      c_reg  <= 1'b0;
      dc_reg <= 1'b0;
      z_reg  <= 1'b0;
    end
    else if (ex_active && (is_add || is_logic))
    begin
      z_reg <= (result == '0); // [RULE11] [RULE6] [RULE7]
      if (is_add)
      begin
        c_reg  <= sum[DATA_W]; // [RULE11]
        dc_reg <= half_sum[4]; // [RULE11]
      end
    end
    else if (bus_wr && dp_addr_reg == alb_pkg::OFS_STATUS)
    begin
      c_reg  <= HWDATA[alb_pkg::ST_C];
      dc_reg <= HWDATA[alb_pkg::ST_DC];
      z_reg  <= HWDATA[alb_pkg::ST_Z];
    end
  end

  // Configuration and file pointer
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      psa_t0_reg <= 1'b0;
      faddr_reg  <= '0;
    end
    else if (bus_wr && dp_addr_reg == alb_pkg::OFS_CONFIG)
      psa_t0_reg <= HWDATA[alb_pkg::CFG_PSA_T0];
    else if (bus_wr && dp_addr_reg == alb_pkg::OFS_FADDR)
      faddr_reg <= HWDATA[FADDR_W-1:0];
  end

  // Port output latch follows every write to the port address
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      port_latch_reg <= '0;
    else if (mem_bus.we && mem_bus.waddr == alb_pkg::FA_PORT)
      port_latch_reg <= mem_bus.wdata;
  end

  // One-cycle prescaler clear on an executed write to timer zero while the prescaler is assigned to it
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      psc_clr_reg <= 1'b0;
    else
      psc_clr_reg <= ex_active && to_file && psa_t0_reg
                     && (ex_f == alb_pkg::FA_TIMER_ZERO); // [RULE2]
  end

  // Outputs straight from flip-flops
  assign HRDATA                   = hrdata_reg;
  assign HREADYOUT                = hready_reg;
  assign HRESP                    = hresp_reg;
  assign PORT_LATCH_OUT           = port_latch_reg;
  assign TIMER_ZERO_PRESCALER_CLR = psc_clr_reg;
  assign PROGRAM_COUNTER          = pc_reg;
endmodule
`default_nettype wire

// ==== tb/alb_core_monitor.sv ====
// Port-level assertions for the datapath core, bound onto its top module.
`timescale 1ns/1ps
`default_nettype none
module alb_monitor #(
  parameter int DATA_W = 8,
  parameter int PC_W   = 13
) (
  // Clock and reset
  input wire logic              MCLK,
  input wire logic              RSTN,
  // Bus side
  input wire logic              HSEL,
  input wire logic [1:0]        HTRANS,
  input wire logic              HREADY,
  input wire logic [31:0]       HRDATA,
  input wire logic              HREADYOUT,
  input wire logic              HRESP,
  // Core side
  input wire logic [DATA_W-1:0] PORT_LATCH_OUT,
  input wire logic              TIMER_ZERO_PRESCALER_CLR,
  input wire logic [PC_W-1:0]   PROGRAM_COUNTER
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RSTN);

  // Taken address phase always costs at least one wait state
  a_wait_after_addr: assert property (
    HSEL && HTRANS[1] && HREADY && HREADYOUT |=> !HREADYOUT)
    else $error("no wait state after accepted address phase");
  // A stall never lasts longer than a taken skip plus a file read
  a_wait_bounded: assert property (
    !HREADYOUT |-> ##[1:8] HREADYOUT)
    else $error("wait state did not end in time");
  a_resp_okay: assert property (!HRESP)
    else $error("error response seen");
  // Read data only moves on completion of a transfer
  a_rdata_hold: assert property (
    $changed(HRDATA) |-> HREADYOUT && !$past(HREADYOUT))
    else $error("read data changed outside completion");
  a_rdata_upper: assert property (HRDATA[31:16] == 16'h0000)
    else $error("upper read data bits not zero");
  // Prescaler clear is a single-cycle pulse
  a_clr_pulse: assert property (
    TIMER_ZERO_PRESCALER_CLR |=> !TIMER_ZERO_PRESCALER_CLR)
    else $error("prescaler clear longer than one cycle");
  // Latch only moves shortly after a bus transfer stalled
  a_latch_cause: assert property (
    $changed(PORT_LATCH_OUT) |-> !$past(HREADYOUT) || !$past(HREADYOUT, 2))
    else $error("port latch changed without a transfer");
  // Program counter only ever steps by one
  a_pc_step: assert property (
    $changed(PROGRAM_COUNTER) |->
      PROGRAM_COUNTER - $past(PROGRAM_COUNTER) == PC_W'(1))
    else $error("program counter jumped");
endmodule

bind alb_core alb_monitor #(.DATA_W(DATA_W), .PC_W(PC_W)) u_mon (
  .MCLK(MCLK), .RSTN(RSTN), .HSEL(HSEL), .HTRANS(HTRANS), .HREADY(HREADY),
  .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .PORT_LATCH_OUT(PORT_LATCH_OUT),
  .TIMER_ZERO_PRESCALER_CLR(TIMER_ZERO_PRESCALER_CLR),
  .PROGRAM_COUNTER(PROGRAM_COUNTER));
`default_nettype wire

// ==== tb/test_arith_logic_bit_ops_datapath.sv ====
// Self-checking bench for the datapath core over its bus.
`timescale 1ns/1ps
`default_nettype none
module test_arith_logic_bit_ops_datapath;
  logic        mclk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0;
  logic        hreadyout, hresp, clr;
  logic [7:0]  pins = 8'h00, latch;
  logic [12:0] pc;
  int          n_fail = 0, samples_checked = 0, n_pulse = 0;

  alb_core u_dut (
    .MCLK(mclk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .PORT_PIN_IN(pins), .PORT_LATCH_OUT(latch),
    .TIMER_ZERO_PRESCALER_CLR(clr), .PROGRAM_COUNTER(pc));

  // 250 MHz clock
  initial
  begin
    forever #2 mclk = ~mclk;
  end
  // Prescaler clear pulses, counted for the timer scenario
  always @(posedge mclk) if (clr === 1'b1) n_pulse <= n_pulse + 1;

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bounded wait for hready sampled high at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 60);
    if (n >= 60)
    begin
      n_fail++;
      wrap_up();
    end
  endtask
  // One single-word transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
    chk("response", 32'h0, {31'h0, hresp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(what, exp, q);
  endtask
  task automatic set_file(input logic [6:0] f, input logic [7:0] v);
    wr(alb_pkg::OFS_FADDR, {25'h0, f});
    wr(alb_pkg::OFS_FDATA, {24'h0, v});
  endtask
  task automatic file_chk(input logic [6:0] f, input logic [7:0] v);
    wr(alb_pkg::OFS_FADDR, {25'h0, f});
    rd_chk("file", alb_pkg::OFS_FDATA, {24'h0, v});
  endtask
  // Instruction word builders
  function automatic logic [31:0] fop(logic [5:0] o, logic d, logic [6:0] f);
    return {18'h0, o, d, f};
  endfunction
  function automatic logic [31:0] bop(logic [3:0] o, int b, logic [6:0] f);
    return {18'h0, o, b[2:0], f};
  endfunction
  function automatic logic [31:0] addl(logic [7:0] k);
    return {18'h0, alb_pkg::OPC_ADD_LIT, 1'b0, k};
  endfunction

  // Reset values, unmapped place reads zero
  task automatic t_reset();
    rd_chk("acc", alb_pkg::OFS_ACC, 32'h0);
    rd_chk("status", alb_pkg::OFS_STATUS, 32'h0);
    rd_chk("config", alb_pkg::OFS_CONFIG, 32'h0);
    rd_chk("pc", alb_pkg::OFS_PC, 32'h0);
    wr(8'h40, 32'h0000_00FF);
    rd_chk("unmapped", 8'h40, 32'h0);
  endtask
  // Literal add and AND, flags preset to catch stale bits
  task automatic t_lit();
    logic [7:0] a0 [5] = '{8'h0F, 8'hF0, 8'hFF, 8'hF0, 8'h3C};
    logic [7:0] k   [5] = '{8'h01, 8'h10, 8'hFF, 8'h0F, 8'hFF};
    logic [7:0] ea  [5] = '{8'h10, 8'h00, 8'hFE, 8'h00, 8'h3C};
    logic [2:0] st0 [5] = '{3'h7, 3'h0, 3'h4, 3'h3, 3'h7};
    logic [2:0] es  [5] = '{3'h2, 3'h5, 3'h3, 3'h7, 3'h3};
    for (int i = 0; i < 5; i++)
    begin
      wr(alb_pkg::OFS_ACC, {24'h0, a0[i]});
      wr(alb_pkg::OFS_STATUS, {29'h0, st0[i]});
      wr(alb_pkg::OFS_INSTR, (i < 3) ? addl(k[i])
         : {18'h0, alb_pkg::OPC_AND_LIT, k[i]});
      rd_chk("acc", alb_pkg::OFS_ACC, {24'h0, ea[i]});
      rd_chk("flags", alb_pkg::OFS_STATUS, {29'h0, es[i]});
    end
  endtask
  // File add and AND with both destinations
  task automatic t_file();
    set_file(7'h7F, 8'h33);
    wr(alb_pkg::OFS_ACC, 32'h11);
    wr(alb_pkg::OFS_INSTR, fop(alb_pkg::OPC_ADD_FILE, 1'b0, 7'h7F));
    rd_chk("acc", alb_pkg::OFS_ACC, 32'h44);
    wr(alb_pkg::OFS_INSTR, fop(alb_pkg::OPC_ADD_FILE, 1'b1, 7'h7F));
    file_chk(7'h7F, 8'h77);
    rd_chk("acc", alb_pkg::OFS_ACC, 32'h44);
    wr(alb_pkg::OFS_STATUS, 32'h3);
    wr(alb_pkg::OFS_ACC, 32'h88);
    wr(alb_pkg::OFS_INSTR, fop(alb_pkg::OPC_AND_FILE, 1'b1, 7'h7F));
    file_chk(7'h7F, 8'h00);
    rd_chk("flags", alb_pkg::OFS_STATUS, 32'h7);
    wr(alb_pkg::OFS_INSTR, fop(alb_pkg::OPC_AND_FILE, 1'b0, 7'h7F));
    rd_chk("acc", alb_pkg::OFS_ACC, 32'h0);
  endtask
  // Every bit index set, then even ones cleared; flags must stay
  task automatic t_bits();
    set_file(7'h21, 8'h00);
    wr(alb_pkg::OFS_STATUS, 32'h7);
    for (int b = 0; b < 8; b++)
      wr(alb_pkg::OFS_INSTR, bop(alb_pkg::OPC_POS_SET, b, 7'h21));
    file_chk(7'h21, 8'hFF);
    for (int b = 0; b < 8; b += 2)
      wr(alb_pkg::OFS_INSTR, bop(alb_pkg::OPC_POS_CLR, b, 7'h21));
    file_chk(7'h21, 8'hAA);
    rd_chk("flags", alb_pkg::OFS_STATUS, 32'h7);
  endtask
  // Skip not taken, then taken with the next instruction dropped
  task automatic t_skip();
    set_file(7'h22, 8'h01);
    wr(alb_pkg::OFS_ACC, 32'h0);
    wr(alb_pkg::OFS_STATUS, 32'h0);
    rd_chk("pc", alb_pkg::OFS_PC, 32'd21);
    wr(alb_pkg::OFS_INSTR, bop(alb_pkg::OPC_POS_TSTZ, 0, 7'h22));
    wr(alb_pkg::OFS_INSTR, addl(8'h01));
    rd_chk("pc", alb_pkg::OFS_PC, 32'd23);
    wr(alb_pkg::OFS_INSTR, bop(alb_pkg::OPC_POS_TSTZ, 1, 7'h22));
    wr(alb_pkg::OFS_INSTR, addl(8'h01));
    wr(alb_pkg::OFS_INSTR, addl(8'h01));
    rd_chk("acc", alb_pkg::OFS_ACC, 32'h2);
    rd_chk("pc", alb_pkg::OFS_PC, 32'd26);
    chk("pc pin", 32'd26, {19'h0, pc});
  endtask
  // Port operand comes from the pins, not the latch
  task automatic t_port();
    set_file(alb_pkg::FA_PORT, 8'hFF);
    chk("latch", 32'hFF, {24'h0, latch});
    pins <= 8'h3C;
    wr(alb_pkg::OFS_INSTR, bop(alb_pkg::OPC_POS_SET, 6, alb_pkg::FA_PORT));
    // Latch is written on the edge that ends the transfer
    @(posedge mclk);
    chk("latch", 32'h7C, {24'h0, latch});
    wr(alb_pkg::OFS_ACC, 32'hF0);
    pins <= 8'h0F;
    wr(alb_pkg::OFS_INSTR, fop(alb_pkg::OPC_AND_FILE, 1'b1, alb_pkg::FA_PORT));
    rd_chk("acc", alb_pkg::OFS_ACC, 32'hF0);
    chk("latch", 32'h00, {24'h0, latch});
  endtask
  // Prescaler clear only for file writes to the count with assignment on
  task automatic t_timer();
    set_file(alb_pkg::FA_TIMER_ZERO, 8'h00);
    wr(alb_pkg::OFS_INSTR,
       bop(alb_pkg::OPC_POS_SET, 0, alb_pkg::FA_TIMER_ZERO));
    wr(alb_pkg::OFS_CONFIG, 32'h1);
    wr(alb_pkg::OFS_INSTR,
       bop(alb_pkg::OPC_POS_CLR, 1, alb_pkg::FA_TIMER_ZERO));
    wr(alb_pkg::OFS_INSTR, fop(alb_pkg::OPC_ADD_FILE, 1'b0,
       alb_pkg::FA_TIMER_ZERO));
    wr(alb_pkg::OFS_INSTR, fop(alb_pkg::OPC_AND_FILE, 1'b1,
       alb_pkg::FA_TIMER_ZERO));
    wr(alb_pkg::OFS_INSTR, bop(alb_pkg::OPC_POS_SET, 0, 7'h02));
    rd_chk("config", alb_pkg::OFS_CONFIG, 32'h1);
    file_chk(alb_pkg::FA_TIMER_ZERO, 8'h01);
    repeat (3) @(posedge mclk);
    chk("pulses", 32'd2, n_pulse);
  endtask

  // Main sequence
  initial
  begin
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_lit();
    t_file();
    t_bits();
    t_skip();
    t_port();
    t_timer();
    wrap_up();
  end
endmodule
`default_nettype wire
